/* File: bench/core_datapath_model.sv */
// Purpose: Instruction datapath driving the core update inputs
// Assumes: put is called just after a falling edge
// Notes:   One update set per clock, held until the next call
module core_datapath_model (
  output core_regs_pkg::core_update_type update_out,
  output logic                           bit_we_out,
  output logic                           bit_value_out,
  output logic                           user0_we_out,
  output logic                           user0_value_out,
  output logic [2:0]                     reg_number_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    update_out = '0;
    {bit_we_out, bit_value_out, user0_we_out, user0_value_out, reg_number_out} = 7'h00;
  end
  task automatic put(input core_regs_pkg::core_update_type u, input logic [6:0] side);
    update_out = u;
    {bit_we_out, bit_value_out, user0_we_out, user0_value_out, reg_number_out} = side;
  endtask
endmodule

/* File: bench/core_regs_assertions.sv */
// Purpose: Port-level checks of the core special registers
// Assumes: One clock, reset active low
// Notes:   Attached by bind at the foot of this file
module core_regs_assertions (
  input wire logic                            clk_sys_in,
  input wire logic                            rst_b_in,
  input wire core_regs_pkg::sfr_req_type      sfr_req_in,
  input wire core_regs_pkg::core_update_type  update_in,
  input wire logic                            bit_op_we_in,
  input wire logic                            bit_op_value_in,
  input wire logic [7:0]                      sfr_rdata_out,
  input wire logic                            sfr_hit_out,
  input wire logic [7:0]                      program_status_word_out,
  input wire logic [7:0]                      stack_top_pointer_out,
  input wire logic [7:0]                      push_address_out,
  input wire logic [15:0]                     data_pointer_out,
  input wire logic [7:0]                      primary_working_reg_out,
  input wire logic [7:0]                      second_operand_reg_out,
  input wire logic                            carry_flag_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       wr;
  logic       rd;
  logic       hit;
  logic [7:0] a;
  assign wr  = sfr_req_in.wr;
  assign rd  = sfr_req_in.rd;
  assign a   = sfr_req_in.addr;
  assign hit = a inside {8'h81, 8'h82, 8'h83, 8'hD0, 8'hE0, 8'hF0};
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);
  // ====================
  // Checks
  AST_PUSH_ADDR: assert property (push_address_out == stack_top_pointer_out + 8'h01)
    else $error("push address not pointer plus one");
  AST_PUSH_INC: assert property (update_in.sp_op == core_regs_pkg::SP_PUSH && !(wr && a == 8'h81)
    |=> stack_top_pointer_out == $past(stack_top_pointer_out) + 8'h01) else $error("push did not step");
  AST_PARITY: assert property (program_status_word_out[0] == ^primary_working_reg_out)
    else $error("parity bit wrong");
  AST_ACC_PARITY: assert property (wr && a == 8'hE0 |=> program_status_word_out[0] == ^$past(sfr_req_in.wdata))
    else $error("parity late after write");
  AST_CARRY_BIT: assert property (carry_flag_out == program_status_word_out[7])
    else $error("carry not in bit 7");
  AST_BOOL_CARRY: assert property (bit_op_we_in && !(wr && a == 8'hD0) |=> carry_flag_out == $past(bit_op_value_in))
    else $error("bit result lost");
  AST_RESET_VAL: assert property ($rose(rst_b_in) |-> stack_top_pointer_out == 8'h07 && data_pointer_out == 16'h0000
    && program_status_word_out == 8'h00 && primary_working_reg_out == 8'h00 && second_operand_reg_out == 8'h00)
    else $error("reset value wrong");
  AST_DATA_POINTER_LOW: assert property (wr && a == 8'h82 |=> data_pointer_out[7:0] == $past(sfr_req_in.wdata))
    else $error("low pointer byte write lost");
  AST_DATA_POINTER_HIGH: assert property (wr && a == 8'h83 |=> data_pointer_out[15:8] == $past(sfr_req_in.wdata))
    else $error("high pointer byte write lost");
  AST_ACC_WR: assert property (wr && a == 8'hE0 |=> primary_working_reg_out == $past(sfr_req_in.wdata))
    else $error("working register write lost");
  AST_B_HOLD: assert property (!(wr && a == 8'hF0) && !update_in.b_we |=> $stable(second_operand_reg_out))
    else $error("second operand changed unasked");
  AST_READ_HIT: assert property (rd && hit |=> sfr_hit_out ##1 !sfr_hit_out || $past(rd))
    else $error("read not answered");
  AST_UNMAPPED: assert property (rd && !hit |=> sfr_rdata_out == 8'h00 && !sfr_hit_out)
    else $error("unmapped read answered");
endmodule

bind cpu_core_special_registers core_regs_assertions u_core_regs_assertions (
  .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .sfr_req_in(sfr_req_in), .update_in(update_in),
  .bit_op_we_in(bit_op_we_in), .bit_op_value_in(bit_op_value_in), .sfr_rdata_out(sfr_rdata_out),
  .sfr_hit_out(sfr_hit_out), .program_status_word_out(program_status_word_out),
  .stack_top_pointer_out(stack_top_pointer_out), .push_address_out(push_address_out),
  .data_pointer_out(data_pointer_out), .primary_working_reg_out(primary_working_reg_out),
  .second_operand_reg_out(second_operand_reg_out), .carry_flag_out(carry_flag_out));

/* File: bench/cpu_core_special_registers_tb.sv */
// Purpose: Self-checking bench of the core special registers
// Assumes: Inputs change on the falling edge
// Notes:   Reference state kept in bench variables
module cpu_core_special_registers_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0, rst_b = 1'b0, bwe, bv, uwe, uv;
  core_regs_pkg::sfr_req_type q = '0;
  core_regs_pkg::core_update_type u = '0, upd;
  logic [3:0] pg = 4'h0;
  logic [2:0] rn, rnw;
  logic [7:0] rdata, program_status_word, spo, pa, acco, bo, bra, sp, dl, dh, acc, b;
  logic [15:0] dpo;
  logic hit, cy, dbw, dbv, duw, duv, c, ac, f0, ov, f1;
  logic [1:0] bk;
  logic [63:0] rr;
  logic [7:0] at [8] = '{8'h81, 8'h82, 8'h83, 8'hD0, 8'hE0, 8'hF0, 8'h80, 8'hA4};
  int n_errors = 0, n_compared = 0, seed = 32'hABA4, cnt = 0;
  always #10 clk_sys = ~clk_sys;
  core_datapath_model u_core_datapath_model (.update_out(upd), .bit_we_out(dbw), .bit_value_out(dbv),
    .user0_we_out(duw), .user0_value_out(duv), .reg_number_out(rnw));
  cpu_core_special_registers u_cpu_core_special_registers (.clk_sys_in(clk_sys), .rst_b_in(rst_b),
    .sfr_req_in(q), .sfr_page_in(pg), .update_in(upd), .bit_op_we_in(dbw), .bit_op_value_in(dbv),
    .psw_user0_we_in(duw), .psw_user0_value_in(duv), .reg_number_in(rnw), .sfr_rdata_out(rdata),
    .sfr_hit_out(hit), .program_status_word_out(program_status_word), .stack_top_pointer_out(spo),
    .push_address_out(pa), .data_pointer_out(dpo), .primary_working_reg_out(acco),
    .second_operand_reg_out(bo), .carry_flag_out(cy), .bank_reg_address_out(bra));
  // ====================
  // Reference model
  function automatic logic [7:0] pswv();
    return {c, ac, f0, bk, ov, f1, ^acc};
  endfunction
  function automatic logic [8:0] rdx(logic [7:0] a);
    case (a)
      8'h81: return {1'b1, sp};
      8'h82: return {1'b1, dl};
      8'h83: return {1'b1, dh};
      8'hD0: return {1'b1, pswv()};
      8'hE0: return {1'b1, acc};
      8'hF0: return {1'b1, b};
      default: return 9'h000;
    endcase
  endfunction
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic do_reset();
    rst_b = 1'b0;
    {sp, dl, dh, acc, b, c, ac, f0, bk, ov, f1} = {8'h07, 32'h0, 7'h00};
    repeat (4) @(negedge clk_sys);
    chk({spo, pa}, 16'h0708);
    rst_b = 1'b1;
  endtask
  task automatic cyc();
    logic [8:0] ex;
    logic [15:0] dp;
    u_core_datapath_model.put(u, {bwe, bv, uwe, uv, rn});
    ex = q.rd ? rdx(q.addr) : 9'h000;
    dp = u.data_pointer_we ? u.data_pointer_value : {dh, dl} + (u.data_pointer_inc ? 16'h0001 : 16'h0000);
    {dh, dl} = dp;
    if (u.acc_we) acc = u.acc_value;
    if (u.b_we) b = u.b_value;
    if (u.carry_we) c = u.carry_value;
    if (bwe) c = bv;
    if (u.half_we) ac = u.half_value;
    if (u.wrap_we) ov = u.wrap_value;
    if (uwe) f0 = uv;
    case (u.sp_op)
      core_regs_pkg::SP_PUSH: sp = sp + 8'h01;
      core_regs_pkg::SP_POP: sp = sp - 8'h01;
      core_regs_pkg::SP_LOAD: sp = u.sp_value;
      default: ;
    endcase
    if (q.wr) begin
      case (q.addr)
        8'h81: sp = q.wdata;
        8'h82: dl = q.wdata;
        8'h83: dh = q.wdata;
        8'hD0: {c, ac, f0, bk, ov, f1} = q.wdata[7:1];
        8'hE0: acc = q.wdata;
        8'hF0: b = q.wdata;
        default: ;
      endcase
    end
    @(posedge clk_sys);
    @(negedge clk_sys);
    chk({7'h00, hit, rdata}, {7'h00, ex});
    chk({8'h00, program_status_word}, {8'h00, pswv()});
    chk({15'h0000, program_status_word[0]}, {15'h0000, ^acc});
    chk({pa, spo}, {sp + 8'h01, sp});
    chk(dpo, {dh, dl});
    chk({acco, 7'h00, cy}, {acc, 7'h00, c});
    chk({8'h00, bo}, {8'h00, b});
    chk({8'h00, bra}, {8'h00, 3'h0, bk, rn});
  endtask
  always @(posedge clk_sys) begin
    cnt++;
    if (cnt == 5000) begin
      n_errors++;
      end_of_test();
    end
  end
  initial begin
    {bwe, bv, uwe, uv, rn} = 7'h00;
    @(negedge clk_sys);
    do_reset();
    for (int i = 0; i < 8; i++) begin
      q = '{1'b0, 1'b1, at[i], 8'h00};
      cyc();
    end
    q = '{1'b1, 1'b1, 8'h81, 8'hFF};
    u.sp_op = core_regs_pkg::SP_PUSH;
    cyc();
    q = '0;
    cyc();
    q = '{1'b1, 1'b0, 8'hE0, 8'h5A};
    {u.acc_we, u.acc_value, u.carry_we, u.carry_value, bwe, bv} = {1'b1, 8'h33, 4'hB};
    cyc();
    for (int k = 0; k < 800; k++) begin
      if (k == 400) do_reset();
      rr = {$random(seed), $random(seed)};
      u = rr[53:0];
      u.flags_we = 1'b0;
      u.data_pointer_inc = u.data_pointer_inc & ~u.data_pointer_we;
      u.sp_op = core_regs_pkg::sp_op_type'({1'b0, rr[63:62]});
      q = '{rr[54], rr[55], at[rr[58:56]], 8'($random(seed))};
      {bwe, bv, uwe, uv, rn, pg} = 11'($random(seed));
      cyc();
    end
    end_of_test();
  end
endmodule

/* File: verilog/core_regs_pkg.sv */
// Purpose: Shared constants and types for the core special registers
// Assumes: Single clock, 8-bit special-function register space
// Notes:   Offsets are special-function addresses
package core_regs_pkg;

  localparam int unsigned DATA_WIDTH = 8;

  // ==========================================================================
  // Register addresses
  localparam logic [7:0] ADDR_STACK_TOP_POINTER   = 8'h81;
  localparam logic [7:0] ADDR_DATA_POINTER_LOW    = 8'h82;
  localparam logic [7:0] ADDR_DATA_POINTER_HIGH   = 8'h83;
  localparam logic [7:0] ADDR_PROGRAM_STATUS_WORD = 8'hD0;
  localparam logic [7:0] ADDR_PRIMARY_WORKING_REG = 8'hE0;
  localparam logic [7:0] ADDR_SECOND_OPERAND_REG  = 8'hF0;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] RST_STACK_TOP_POINTER = 8'h07;
  localparam logic [7:0] RST_ZERO_BYTE         = 8'h00;

  // ==========================================================================
  // Status word bit positions
  localparam int unsigned PSW_CARRY_BIT    = 7;
  localparam int unsigned PSW_HALF_BIT     = 6;
  localparam int unsigned PSW_USER0_BIT    = 5;
  localparam int unsigned PSW_BANK_HI_BIT  = 4;
  localparam int unsigned PSW_BANK_LO_BIT  = 3;
  localparam int unsigned PSW_WRAP_BIT     = 2;
  localparam int unsigned PSW_USER1_BIT    = 1;
  localparam int unsigned PSW_ODD_BIT      = 0;

  // ==========================================================================
  // Register bank layout
  localparam int unsigned BANK_SIZE_BYTES = 8;
  localparam int unsigned BANK_COUNT      = 4;
  localparam logic [7:0]  BANK_BASE_ADDR  = 8'h00;
  localparam logic [7:0]  PUSH_STEP       = 8'h01;
  localparam logic [7:0]  BYTE_ONES       = 8'hFF;

  // ==========================================================================
  // Datapath update commands
  typedef enum logic [2:0] {
    SP_HOLD,
    SP_PUSH,
    SP_POP,
    SP_LOAD
  } sp_op_type;

  typedef struct packed {
    logic       carry;
    logic       half_carry;
    logic       user_zero;
    logic [1:0] bank;
    logic       signed_wrap;
    logic       user_one;
  } psw_fields_type;

  // Datapath-side update request, one cycle per instruction stage
  typedef struct packed {
    logic           acc_we;
    logic [7:0]     acc_value;
    logic           b_we;
    logic [7:0]     b_value;
    logic           data_pointer_we;
    logic [15:0]    data_pointer_value;
    logic           data_pointer_inc;
    logic           flags_we;
    logic           carry_we;
    logic           carry_value;
    logic           half_we;
    logic           half_value;
    logic           wrap_we;
    logic           wrap_value;
    sp_op_type      sp_op;
    logic [7:0]     sp_value;
  } core_update_type;

  // Special-function bus request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_type;

  typedef struct packed {
    logic [7:0] stack_top_pointer;
    logic [7:0] data_pointer_low;
    logic [7:0] data_pointer_high;
    logic [7:0] primary_working_reg;
    logic [7:0] second_operand_reg;
    psw_fields_type program_status_word;
  } core_state_type;

endpackage

/* File: verilog/cpu_core_special_registers.sv */
// Purpose: Core special registers of an 8-bit one-clock-per-step core
// Assumes: Inputs synchronous to clk_sys_in; one datapath update per cycle
// Notes:   Special-function writes take precedence over datapath updates
module cpu_core_special_registers #(
  parameter int unsigned BANKS = core_regs_pkg::BANK_COUNT
) (
  input  wire logic                         clk_sys_in,
  input  wire logic                         rst_b_in,
  input  wire core_regs_pkg::sfr_req_type   sfr_req_in,
  input  wire logic [3:0]                   sfr_page_in,
  input  wire core_regs_pkg::core_update_type update_in,
  input  wire logic                         bit_op_we_in,
  input  wire logic                         bit_op_value_in,
  input  wire logic                         psw_user0_we_in,
  input  wire logic                         psw_user0_value_in,
  input  wire logic [2:0]                   reg_number_in,
  output logic [7:0]                        sfr_rdata_out,
  output logic                              sfr_hit_out,
  output logic [7:0]                        program_status_word_out,
  output logic [7:0]                        stack_top_pointer_out,
  output logic [7:0]                        push_address_out,
  output logic [15:0]                       data_pointer_out,
  output logic [7:0]                        primary_working_reg_out,
  output logic [7:0]                        second_operand_reg_out,
  output logic                              carry_flag_out,
  output logic [7:0]                        bank_reg_address_out
);

  // ==========================================================================
  // State
  typedef struct packed {
    core_regs_pkg::core_state_type core;
    logic [7:0]                    rdata;
    logic                          hit;
    logic [7:0]                    push_addr;
    logic [7:0]                    bank_addr;
    logic                          odd;
  } state_type;

  state_type state_q;
  state_type state_d;
  logic      odd_next;
  logic [7:0] acc_next;

  // Page select is ignored: every core register is visible on every page
  logic [3:0] page_unused;
  assign page_unused = sfr_page_in;

  // ==========================================================================
  // Parity of the next working register value
  odd_ones_calc #(
    .WIDTH(core_regs_pkg::DATA_WIDTH)
  ) u_odd (
    .word_in (acc_next),
    .odd_out (odd_next)
  );

  function automatic logic [7:0] psw_pack(input core_regs_pkg::psw_fields_type p, input logic odd);
    logic [7:0] v;
    v = core_regs_pkg::RST_ZERO_BYTE;
    v[core_regs_pkg::PSW_CARRY_BIT]   = p.carry;
    v[core_regs_pkg::PSW_HALF_BIT]    = p.half_carry;
    v[core_regs_pkg::PSW_USER0_BIT]   = p.user_zero;
    v[core_regs_pkg::PSW_BANK_HI_BIT] = p.bank[1];
    v[core_regs_pkg::PSW_BANK_LO_BIT] = p.bank[0];
    v[core_regs_pkg::PSW_WRAP_BIT]    = p.signed_wrap;
    v[core_regs_pkg::PSW_USER1_BIT]   = p.user_one;
    v[core_regs_pkg::PSW_ODD_BIT]     = odd;
    return v;
  endfunction

  // ==========================================================================
  // Next-state logic
  always_comb begin
    logic [15:0] data_pointer;
    logic [7:0]  sfr_val;
    state_d = state_q;
    data_pointer    = {state_q.core.data_pointer_high, state_q.core.data_pointer_low};
    sfr_val = core_regs_pkg::RST_ZERO_BYTE;

    // Datapath updates
    if (update_in.acc_we) begin
      state_d.core.primary_working_reg = update_in.acc_value;
    end
    if (update_in.b_we) begin
      state_d.core.second_operand_reg = update_in.b_value;
    end
    if (update_in.data_pointer_we) begin
      data_pointer = update_in.data_pointer_value;
    end else if (update_in.data_pointer_inc) begin
      data_pointer = data_pointer + 16'h0001;
    end
    state_d.core.data_pointer_low  = data_pointer[7:0];
    state_d.core.data_pointer_high = data_pointer[15:8];
    if (update_in.carry_we) begin
      state_d.core.program_status_word.carry = update_in.carry_value;
    end
    if (bit_op_we_in) begin
      state_d.core.program_status_word.carry = bit_op_value_in;
    end
    if (update_in.half_we) begin
      state_d.core.program_status_word.half_carry = update_in.half_value;
    end
    if (update_in.wrap_we) begin
      state_d.core.program_status_word.signed_wrap = update_in.wrap_value;
    end
    if (psw_user0_we_in) begin
      state_d.core.program_status_word.user_zero = psw_user0_value_in;
    end
    case (update_in.sp_op)
      core_regs_pkg::SP_PUSH: begin
        state_d.core.stack_top_pointer = state_q.core.stack_top_pointer + core_regs_pkg::PUSH_STEP;
      end
      core_regs_pkg::SP_POP: begin
        state_d.core.stack_top_pointer = state_q.core.stack_top_pointer - core_regs_pkg::PUSH_STEP;
      end
      core_regs_pkg::SP_LOAD: begin
        state_d.core.stack_top_pointer = update_in.sp_value;
      end
      default: begin
      end
    endcase

    // Special-function writes, any page
    if (sfr_req_in.wr) begin
      if (sfr_req_in.addr == core_regs_pkg::ADDR_STACK_TOP_POINTER) begin
        state_d.core.stack_top_pointer = sfr_req_in.wdata;
      end else if (sfr_req_in.addr == core_regs_pkg::ADDR_DATA_POINTER_LOW) begin
        state_d.core.data_pointer_low = sfr_req_in.wdata;
      end else if (sfr_req_in.addr == core_regs_pkg::ADDR_DATA_POINTER_HIGH) begin
        state_d.core.data_pointer_high = sfr_req_in.wdata;
      end else if (sfr_req_in.addr == core_regs_pkg::ADDR_PROGRAM_STATUS_WORD) begin
        state_d.core.program_status_word.carry       = sfr_req_in.wdata[core_regs_pkg::PSW_CARRY_BIT];
        state_d.core.program_status_word.half_carry  = sfr_req_in.wdata[core_regs_pkg::PSW_HALF_BIT];
        state_d.core.program_status_word.user_zero   = sfr_req_in.wdata[core_regs_pkg::PSW_USER0_BIT];
        state_d.core.program_status_word.bank        = {sfr_req_in.wdata[core_regs_pkg::PSW_BANK_HI_BIT],
                                        sfr_req_in.wdata[core_regs_pkg::PSW_BANK_LO_BIT]};
        state_d.core.program_status_word.signed_wrap = sfr_req_in.wdata[core_regs_pkg::PSW_WRAP_BIT];
        state_d.core.program_status_word.user_one    = sfr_req_in.wdata[core_regs_pkg::PSW_USER1_BIT];
      end else if (sfr_req_in.addr == core_regs_pkg::ADDR_PRIMARY_WORKING_REG) begin
        state_d.core.primary_working_reg = sfr_req_in.wdata;
      end else if (sfr_req_in.addr == core_regs_pkg::ADDR_SECOND_OPERAND_REG) begin
        state_d.core.second_operand_reg = sfr_req_in.wdata;
      end
    end

    // Parity follows the register value that is being stored
    state_d.odd = odd_next;

    // Push address is the pre-incremented pointer
    state_d.push_addr = state_d.core.stack_top_pointer + core_regs_pkg::PUSH_STEP;

    // Register-number to internal RAM address, banks of eight at the bottom
    state_d.bank_addr = core_regs_pkg::BANK_BASE_ADDR
                        + {3'h0, state_d.core.program_status_word.bank, reg_number_in};

    // Special-function reads
    state_d.hit = 1'b0;
    if (sfr_req_in.addr == core_regs_pkg::ADDR_STACK_TOP_POINTER) begin
      sfr_val     = state_q.core.stack_top_pointer;
      state_d.hit = 1'b1;
    end else if (sfr_req_in.addr == core_regs_pkg::ADDR_DATA_POINTER_LOW) begin
      sfr_val     = state_q.core.data_pointer_low;
      state_d.hit = 1'b1;
    end else if (sfr_req_in.addr == core_regs_pkg::ADDR_DATA_POINTER_HIGH) begin
      sfr_val     = state_q.core.data_pointer_high;
      state_d.hit = 1'b1;
    end else if (sfr_req_in.addr == core_regs_pkg::ADDR_PROGRAM_STATUS_WORD) begin
      sfr_val     = psw_pack(state_q.core.program_status_word, state_q.odd);
      state_d.hit = 1'b1;
    end else if (sfr_req_in.addr == core_regs_pkg::ADDR_PRIMARY_WORKING_REG) begin
      sfr_val     = state_q.core.primary_working_reg;
      state_d.hit = 1'b1;
    end else if (sfr_req_in.addr == core_regs_pkg::ADDR_SECOND_OPERAND_REG) begin
      sfr_val     = state_q.core.second_operand_reg;
      state_d.hit = 1'b1;
    end
    if (!sfr_req_in.rd) begin
      state_d.hit = 1'b0;
      sfr_val     = core_regs_pkg::RST_ZERO_BYTE;
    end
    state_d.rdata = sfr_val;
  end

  // Working register value that the next edge will store
  always_comb begin
    acc_next = state_q.core.primary_working_reg;
    if (update_in.acc_we) begin
      acc_next = update_in.acc_value;
    end
    if (sfr_req_in.wr && sfr_req_in.addr == core_regs_pkg::ADDR_PRIMARY_WORKING_REG) begin
      acc_next = sfr_req_in.wdata;
    end
  end

  // ==========================================================================
  // State register; every update completes in one core clock
  always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_q                          <= '0;
      state_q.core.stack_top_pointer   <= core_regs_pkg::RST_STACK_TOP_POINTER;
      state_q.push_addr                <= core_regs_pkg::RST_STACK_TOP_POINTER + core_regs_pkg::PUSH_STEP;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // Outputs
  assign sfr_rdata_out           = state_q.rdata;
  assign sfr_hit_out             = state_q.hit;
  assign program_status_word_out = psw_pack(state_q.core.program_status_word, state_q.odd);
  assign stack_top_pointer_out   = state_q.core.stack_top_pointer;
  assign push_address_out        = state_q.push_addr;
  assign data_pointer_out        = {state_q.core.data_pointer_high, state_q.core.data_pointer_low};
  assign primary_working_reg_out = state_q.core.primary_working_reg;
  assign second_operand_reg_out  = state_q.core.second_operand_reg;
  assign carry_flag_out          = state_q.core.program_status_word.carry;
  assign bank_reg_address_out    = state_q.bank_addr;

endmodule

/* File: verilog/odd_ones_calc.sv */
// Purpose: Odd count of one bits over a word
// Assumes: Purely combinational
// Notes:   Used for the status word parity bit
module odd_ones_calc #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic [WIDTH-1:0] word_in,
  output logic                  odd_out
);

  // ==========================================================================
  // Reduction
  assign odd_out = ^word_in;

endmodule
